// >>> pds_sched.v
`timescale 1ns/100ps
`default_nettype none
`include "pds_map.vh"

module pds_sched #(
	parameter TICK_CYC = `PDS_TICK_CYC,
	parameter DATA_W   = `PDS_DATA_W,
	parameter DEPTH    = `PDS_FIFO_DEPTH,
	parameter AW       = 3
) (
	// clock and reset
	input  wire              clk_sys,
	input  wire              srst,
	// register port
	input  wire [3:0]        reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [31:0]       reg_rdata,
	// sync broadcast request to the can controller
	output reg               sync_tx,
	// outbound receive-object frames
	output reg               rpdo_valid,
	input  wire              rpdo_ready,
	output reg  [DATA_W-1:0] rpdo_data,
	// inbound transmit-object frames
	input  wire              tpdo_valid,
	input  wire [DATA_W-1:0] tpdo_data,
	output reg               tpdo_update
);

	// ==========================================================
	// constants
	// ==========================================================
	// full-width copies, sliced on purpose into the 16-bit counters
	localparam integer TICK_I   = TICK_CYC - 1;
	localparam integer SYNC_I   = `PDS_SYNC_RST;
	localparam integer MS_I     = `PDS_MS_TICKS;
	localparam [15:0] TICK_LAST = TICK_I[15:0]; // divider wrap
	localparam [15:0] SYNC_RST  = SYNC_I[15:0]; // 50 ms in ticks
	localparam [15:0] MS_TICKS  = MS_I[15:0];   // ticks per ms
	localparam [7:0]  CYC_MAX   = `PDS_TYPE_CYC_MAX;

	// ==========================================================
	// software registers
	// ==========================================================
	reg               ctrl_en;   // scheduler running
	reg [15:0]        sync_per;  // sync period, ticks
	reg [7:0]         rx_type;   // receive object type
	reg [DATA_W-1:0]  rx_data;   // mapped outbound value
	reg [7:0]         tx_type;   // transmit object type
	reg [15:0]        tx_event;  // slave event timer, ms
	reg [15:0]        tx_inh;    // slave inhibit time, ticks
	reg [DATA_W-1:0]  tx_data;   // last inbound value

	// ==========================================================
	// status flags
	// ==========================================================
	reg               st_fresh;  // new inbound data
	reg               st_inh;    // frame inside inhibit gap
	reg               st_evt;    // event period missed

	// ==========================================================
	// internal state
	// ==========================================================
	reg [15:0]        tick_cnt;  // divider count
	reg               tick;      // one-cycle 100 us enable
	reg [15:0]        sync_cnt;  // ticks since last sync
	reg               sync_ev;   // internal sync strobe
	reg [7:0]         cyc_cnt;   // syncs since last cyclic send
	reg               rx_chg;    // outbound value changed
	reg               pend;      // frame waiting for fifo
	reg [DATA_W-1:0]  pend_data; // frame waiting for fifo
	reg [15:0]        inh_cnt;   // inhibit ticks remaining
	reg [19:0]        evt_cnt;   // event ticks remaining

	// fifo wiring
	wire              f_in_ready;
	wire              f_out_valid;
	wire [DATA_W-1:0] f_out_data;
	wire              f_out_ready;

	// ==========================================================
	// decode helpers
	// ==========================================================
	wire wr_ctrl  = reg_wr && (reg_addr == `PDS_REG_CTRL);
	wire wr_sync  = reg_wr && (reg_addr == `PDS_REG_SYNC);
	wire wr_rxt   = reg_wr && (reg_addr == `PDS_REG_RX_TYPE);
	wire wr_rxd   = reg_wr && (reg_addr == `PDS_REG_RX_DATA);
	wire wr_txt   = reg_wr && (reg_addr == `PDS_REG_TX_TYPE);
	wire wr_evt   = reg_wr && (reg_addr == `PDS_REG_TX_EVENT);
	wire wr_inh   = reg_wr && (reg_addr == `PDS_REG_TX_INH);
	wire rd_stat  = reg_rd && (reg_addr == `PDS_REG_STATUS);

	// type classes; 255 folds onto 254 everywhere
	wire rx_async = (rx_type == `PDS_TYPE_ASYNC) ||
			(rx_type == `PDS_TYPE_ASYNC_D);
	wire rx_chg_t = (rx_type == `PDS_TYPE_CHG) || rx_async;
	wire rx_cyc_t = (rx_type != `PDS_TYPE_CHG) && (rx_type <= CYC_MAX);
	wire tx_async = (tx_type == `PDS_TYPE_ASYNC) ||
			(tx_type == `PDS_TYPE_ASYNC_D);

	// cyclic send fires on the Nth sync
	wire cyc_hit  = sync_ev && rx_cyc_t && (cyc_cnt + 8'h01 == rx_type);

	// the fifo push is the pending frame
	wire push_ok  = pend && f_in_ready;

	// inbound frame timing checks apply to async types with timers
	wire tx_chk   = tx_async && ((tx_event != 16'h0000) || (tx_inh != 16'h0000));
	// widened first so the product never wraps at 16 bits
	wire [19:0] evt_load = {4'h0, tx_event} * {4'h0, MS_TICKS};

	// ==========================================================
	// tick divider: one clock, slow rates as enables
	// ==========================================================
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b0;
		end
		else if (tick_cnt == TICK_LAST)
		begin
			tick_cnt <= 16'h0000;
			tick     <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + 16'h0001;
			tick     <= 1'b0;
		end
	end

	// ==========================================================
	// sync period timer
	// ==========================================================
	// a zero period stops sync rather than flooding the bus
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			sync_cnt <= 16'h0000;
			sync_ev  <= 1'b0;
			sync_tx  <= 1'b0;
		end
		else
		begin
			sync_ev <= 1'b0;
			sync_tx <= 1'b0;
			if (!ctrl_en || sync_per == 16'h0000)
				sync_cnt <= 16'h0000;
			else if (tick)
			begin
				if (sync_cnt + 16'h0001 >= sync_per)
				begin
					sync_cnt <= 16'h0000;
					sync_ev  <= 1'b1;
					sync_tx  <= 1'b1;
				end
				else
					sync_cnt <= sync_cnt + 16'h0001;
			end
		end
	end

	// ==========================================================
	// register writes
	// ==========================================================
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			ctrl_en  <= 1'b0;
			sync_per <= SYNC_RST;
			rx_type  <= `PDS_TYPE_ASYNC_D;
			rx_data  <= {DATA_W{1'b0}};
			tx_type  <= `PDS_TYPE_ASYNC_D;
			tx_event <= 16'h0000;
			tx_inh   <= 16'h0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_en <= reg_wdata[`PDS_CTRL_EN];
			if (wr_sync)
				sync_per <= reg_wdata[15:0];
			if (wr_rxt)
				rx_type <= reg_wdata[7:0];
			if (wr_rxd)
				rx_data <= reg_wdata[DATA_W-1:0];
			if (wr_txt)
				tx_type <= reg_wdata[7:0];
			if (wr_evt)
				tx_event <= reg_wdata[15:0];
			if (wr_inh)
				tx_inh <= reg_wdata[15:0];
		end
	end

	// ==========================================================
	// outbound scheduling
	// ==========================================================
	// the fifo queues frames and one more waits in the pending slot; a newer value overwrites that one, so the
	// slave always gets the latest data even under back-pressure
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			rx_chg    <= 1'b0;
			cyc_cnt   <= 8'h00;
			pend      <= 1'b0;
			pend_data <= {DATA_W{1'b0}};
		end
		else
		begin
			// change detect on the mapped value
			if (wr_rxd && reg_wdata[DATA_W-1:0] != rx_data)
				rx_chg <= 1'b1;
			else if (rx_chg && rx_chg_t && ctrl_en)
				rx_chg <= 1'b0;
			// sync counting for cyclic types
			if (!rx_cyc_t || !ctrl_en)
				cyc_cnt <= 8'h00;
			else if (cyc_hit)
				cyc_cnt <= 8'h00;
			else if (sync_ev)
				cyc_cnt <= cyc_cnt + 8'h01;
			// frame request
			if (ctrl_en && rx_chg && rx_chg_t)
			begin
				pend      <= 1'b1;
				pend_data <= rx_data;
			end
			else if (ctrl_en && cyc_hit)
			begin
				pend      <= 1'b1;
				pend_data <= rx_data;
			end
			else if (push_ok)
				pend <= 1'b0;
		end
	end

	// ==========================================================
	// outbound fifo and output stage
	// ==========================================================
	pds_fifo #(
		.W     (DATA_W),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_valid  (pend),
		.in_ready  (f_in_ready),
		.in_data   (pend_data),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// output register refills when empty or being taken
	assign f_out_ready = !rpdo_valid || rpdo_ready;

	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			rpdo_valid <= 1'b0;
			rpdo_data  <= {DATA_W{1'b0}};
		end
		else if (f_out_ready)
		begin
			rpdo_valid <= f_out_valid;
			if (f_out_valid)
				rpdo_data <= f_out_data;
		end
	end

	// ==========================================================
	// inbound frames
	// ==========================================================
	// the master takes every frame as valid at once, whatever type
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			tx_data     <= {DATA_W{1'b0}};
			tpdo_update <= 1'b0;
			st_fresh    <= 1'b0;
		end
		else
		begin
			tpdo_update <= tpdo_valid;
			if (tpdo_valid)
				tx_data <= tpdo_data;
			// set beats the read-clear
			if (tpdo_valid)
				st_fresh <= 1'b1;
			else if (rd_stat)
				st_fresh <= 1'b0;
		end
	end

	// ==========================================================
	// slave timing watch for asynchronous transmit types
	// ==========================================================
	// only monitors; the slave itself owns the timers
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			inh_cnt <= 16'h0000;
			evt_cnt <= 20'h00000;
			st_inh  <= 1'b0;
			st_evt  <= 1'b0;
		end
		else
		begin
			if (!tx_chk || !ctrl_en)
			begin
				inh_cnt <= 16'h0000;
				evt_cnt <= evt_load;
			end
			else if (tpdo_valid)
			begin
				inh_cnt <= tx_inh;
				evt_cnt <= evt_load;
			end
			else if (tick)
			begin
				if (inh_cnt != 16'h0000)
					inh_cnt <= inh_cnt - 16'h0001;
				if (evt_cnt > 20'h00001)
					evt_cnt <= evt_cnt - 20'h00001;
				else if (tx_event != 16'h0000)
					evt_cnt <= evt_load;
			end
			// frame inside the inhibit gap; set wins
			if (tx_chk && ctrl_en && tpdo_valid && inh_cnt != 16'h0000)
				st_inh <= 1'b1;
			else if (rd_stat)
				st_inh <= 1'b0;
			// event period ran out with no frame; set wins
			if (tx_chk && ctrl_en && !tpdo_valid && tick &&
					tx_event != 16'h0000 && evt_cnt == 20'h00001)
				st_evt <= 1'b1;
			else if (rd_stat)
				st_evt <= 1'b0;
		end
	end

	// ==========================================================
	// register reads, data one cycle after the strobe
	// ==========================================================
	always @(posedge clk_sys)
	begin
		if (srst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			reg_rdata <= 32'h00000000;
			if (reg_addr == `PDS_REG_CTRL)
				reg_rdata[`PDS_CTRL_EN] <= ctrl_en;
			else if (reg_addr == `PDS_REG_SYNC)
				reg_rdata[15:0] <= sync_per;
			else if (reg_addr == `PDS_REG_RX_TYPE)
				reg_rdata[7:0] <= rx_type;
			else if (reg_addr == `PDS_REG_RX_DATA)
				reg_rdata[DATA_W-1:0] <= rx_data;
			else if (reg_addr == `PDS_REG_TX_TYPE)
				reg_rdata[7:0] <= tx_type;
			else if (reg_addr == `PDS_REG_TX_EVENT)
				reg_rdata[15:0] <= tx_event;
			else if (reg_addr == `PDS_REG_TX_INH)
				reg_rdata[15:0] <= tx_inh;
			else if (reg_addr == `PDS_REG_TX_DATA)
				reg_rdata[DATA_W-1:0] <= tx_data;
			else if (reg_addr == `PDS_REG_STATUS)
			begin
				reg_rdata[`PDS_ST_FRESH]   <= st_fresh;
				reg_rdata[`PDS_ST_INH_ERR] <= st_inh;
				reg_rdata[`PDS_ST_EVT_ERR] <= st_evt;
				reg_rdata[`PDS_ST_FULL]    <= !f_in_ready;
				reg_rdata[`PDS_ST_PEND]    <= pend;
			end
		end
		else
			reg_rdata <= 32'h00000000; // data stand one cycle only
	end

endmodule // pds_sched

`default_nettype wire

// >>> pds_map.vh
`ifndef PDS_MAP_VH
`define PDS_MAP_VH

// ==========================================================
// register indexes on the plain register port
// ==========================================================
`define PDS_REG_CTRL     4'h0
`define PDS_REG_SYNC     4'h1
`define PDS_REG_RX_TYPE  4'h2
`define PDS_REG_RX_DATA  4'h3
`define PDS_REG_TX_TYPE  4'h4
`define PDS_REG_TX_EVENT 4'h5
`define PDS_REG_TX_INH   4'h6
`define PDS_REG_TX_DATA  4'h7
`define PDS_REG_STATUS   4'h8

// ==========================================================
// field positions
// ==========================================================
`define PDS_CTRL_EN      0
`define PDS_ST_FRESH     0
`define PDS_ST_INH_ERR   1
`define PDS_ST_EVT_ERR   2
`define PDS_ST_FULL      3
`define PDS_ST_PEND      4

// ==========================================================
// transmission type codes
// ==========================================================
`define PDS_TYPE_CHG     8'h00
`define PDS_TYPE_CYC_MAX 8'hF0
`define PDS_TYPE_ASYNC   8'hFE
`define PDS_TYPE_ASYNC_D 8'hFF

// ==========================================================
// timing and reset values
// ==========================================================
`define PDS_CLK_MHZ      50
`define PDS_TICK_US      100
`define PDS_TICK_CYC     (`PDS_TICK_US * `PDS_CLK_MHZ)
`define PDS_SYNC_MS      50
`define PDS_SYNC_RST     (`PDS_SYNC_MS * 1000 / `PDS_TICK_US)
`define PDS_MS_TICKS     (1000 / `PDS_TICK_US)
`define PDS_FIFO_DEPTH   8
`define PDS_DATA_W       32

`endif

// >>> pds_fifo.v
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// small synchronous fifo, valid/ready on both sides
// ==========================================================
module pds_fifo #(
	parameter W     = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         srst,
	// fill side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// drain side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] mem [0:DEPTH-1]; // storage words
	reg [AW-1:0] wr_ptr;         // next write slot
	reg [AW-1:0] rd_ptr;         // next read slot
	reg [AW:0]   count;          // words held

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;
	// full-width copies, sliced on purpose to count and pointer width
	localparam integer  DEPTH_I  = DEPTH;
	localparam integer  LAST_I   = DEPTH - 1;
	localparam [AW:0]   FULL_CNT = DEPTH_I[AW:0];
	localparam [AW-1:0] LAST     = LAST_I[AW-1:0];

	assign in_ready  = (count != FULL_CNT);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];

	// ==========================================================
	// pointers and count
	// ==========================================================
	always @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
		if (srst)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == LAST) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == LAST) ? {AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end

endmodule // pds_fifo

`default_nettype wire

// >>> pds_sched_end_marker_none.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> pds_sched_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "pds_map.vh"
// ==========================================================
// port checker for the scheduler
// ==========================================================
module pds_chk #(
	parameter TICK_CYC = 10,
	parameter DATA_W   = 32
) (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              srst,
	// register port
	input wire logic [3:0]        reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	// frame ports
	input wire logic              sync_tx,
	input wire logic              rpdo_valid,
	input wire logic              rpdo_ready,
	input wire logic [DATA_W-1:0] rpdo_data,
	input wire logic              tpdo_valid,
	input wire logic [DATA_W-1:0] tpdo_data,
	input wire logic              tpdo_update
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic        en;       // mirrored enable
	logic [7:0]  rx_type;  // mirrored receive type
	logic [15:0] sync_per; // mirrored period in ticks
	logic [31:0] rx_cur;   // mirrored outbound word
	logic [3:0]  chg_age;  // cycles since a changing write
	logic [7:0]  n_sync;   // syncs since type or enable write or the last cyclic send
	logic [31:0] gap;      // cycles since the last sync
	logic        seen;     // a whole period can be measured
	wire wr_cfg = reg_wr && (reg_addr == `PDS_REG_CTRL || reg_addr == `PDS_REG_SYNC);
	wire chg_t = rx_type == `PDS_TYPE_CHG || rx_type >= `PDS_TYPE_ASYNC;
	wire cyc_t = rx_type != 8'h00 && rx_type <= `PDS_TYPE_CYC_MAX;
	wire chg_wr = reg_wr && reg_addr == `PDS_REG_RX_DATA && reg_wdata != rx_cur && en;
	// ==========================================================
	// mirror of the configuration seen on the register port
	// ==========================================================
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			en       <= 1'b0;
			rx_type  <= 8'hFF;
			sync_per <= 16'h01F4;
			rx_cur   <= 32'h0;
			chg_age  <= 4'hF;
			n_sync   <= 8'h00;
			gap      <= 32'h0;
			seen     <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == `PDS_REG_CTRL)
				en <= reg_wdata[0];
			if (reg_wr && reg_addr == `PDS_REG_SYNC)
				sync_per <= reg_wdata[15:0];
			if (reg_wr && reg_addr == `PDS_REG_RX_TYPE)
				rx_type <= reg_wdata[7:0];
			if (reg_wr && reg_addr == `PDS_REG_RX_DATA)
				rx_cur <= reg_wdata;
			// saturate so old changes never look recent
			chg_age <= chg_wr ? 4'h0 : (chg_age == 4'hF ? 4'hF : chg_age + 4'h1);
			// count restarts whenever type or enable is rewritten
			if (reg_wr && (reg_addr == `PDS_REG_CTRL || reg_addr == `PDS_REG_RX_TYPE))
				n_sync <= 8'h00;
			else if (sync_tx)
				n_sync <= (n_sync + 8'h01 == rx_type) ? 8'h00 : n_sync + 8'h01;
			gap  <= sync_tx ? 32'h0 : gap + 32'h1;
			seen <= wr_cfg ? 1'b0 : (sync_tx ? 1'b1 : seen);
		end
	end
	// ==========================================================
	// assertions
	// ==========================================================
	sync_pulse_a: assert property (sync_tx |=> !sync_tx)
		else $error("sync request longer than one cycle");
	sync_period_a: assert property (sync_tx && seen |-> gap == sync_per * TICK_CYC - 1)
		else $error("sync spacing differs from the period");
	sync_off_a: assert property (!en && !$past(en) |-> !sync_tx)
		else $error("sync while disabled");
	rpdo_hold_a: assert property (rpdo_valid && !rpdo_ready |=> rpdo_valid && $stable(rpdo_data))
		else $error("outbound frame dropped or changed while waiting");
	rx_chg_send_a: assert property (chg_wr && chg_t && rpdo_ready && !rpdo_valid
		|-> ##[1:8] (rpdo_valid && rpdo_data == rx_cur))
		else $error("changed word not sent");
	rx_quiet_a: assert property ($rose(rpdo_valid) && chg_t |-> chg_age < 4'h8)
		else $error("frame sent without a change");
	cyc_send_a: assert property (sync_tx && cyc_t && en && n_sync + 8'h01 == rx_type
		|-> ##[1:4] rpdo_valid)
		else $error("cyclic frame missing after N syncs");
	tpdo_upd_a: assert property (tpdo_valid |=> tpdo_update)
		else $error("inbound frame not flagged");
	tpdo_idle_a: assert property (!tpdo_valid |=> !tpdo_update)
		else $error("update without an inbound frame");
	cover property (sync_tx);
	cover property (rpdo_valid && !rpdo_ready);
	cover property (tpdo_update);
endmodule // pds_chk
bind pds_sched pds_chk #(.TICK_CYC(TICK_CYC), .DATA_W(DATA_W)) u_chk (
	.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_tx(sync_tx),
	.rpdo_valid(rpdo_valid), .rpdo_ready(rpdo_ready), .rpdo_data(rpdo_data),
	.tpdo_valid(tpdo_valid), .tpdo_data(tpdo_data), .tpdo_update(tpdo_update));
`default_nettype wire

// >>> pds_slave.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// behavioural slave node on the far side
// ==========================================================
module pds_slave (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// controls from the bench
	input  wire logic        stall,
	input  wire logic        sync_apply,
	// outbound frames from the master
	input  wire logic        sync_tx,
	input  wire logic        rpdo_valid,
	output logic             rpdo_ready,
	input  wire logic [31:0] rpdo_data,
	// inbound frames to the master
	output logic             tpdo_valid = 1'b0,
	output logic [31:0]      tpdo_data = 32'h0
);
	logic [31:0] n_rx;    // frames taken
	logic [31:0] last_rx; // newest word taken
	logic [31:0] held;    // word waiting for a sync
	logic [31:0] applied; // word in use by the drive
	assign rpdo_ready = !stall; // a stalled node takes nothing
	// take frames, apply at once or at the next sync
	always @(posedge clk_sys)
	begin
		if (srst)
		begin
			n_rx    <= 32'h0;
			last_rx <= 32'h0;
			held    <= 32'h0;
			applied <= 32'h0;
		end
		else
		begin
			if (rpdo_valid && rpdo_ready)
			begin
				n_rx    <= n_rx + 32'h1;
				last_rx <= rpdo_data;
				held    <= rpdo_data;
				if (!sync_apply)
					applied <= rpdo_data;
			end
			if (sync_tx && sync_apply)
				applied <= held;
		end
	end
	// one inbound frame; data is scrambled outside it
	task automatic send(input logic [31:0] d);
		@(posedge clk_sys);
		tpdo_valid <= 1'b1;
		tpdo_data  <= d;
		@(posedge clk_sys);
		tpdo_valid <= 1'b0;
		tpdo_data  <= ~d;
	endtask
endmodule // pds_slave
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pds_map.vh"
// ==========================================================
// top bench: register calls and frame checks
// ==========================================================
module tb_top;
	localparam TICK = 10; // short tick keeps the run small
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        stall = 1'b0;      // slave refuses frames
	logic        sync_apply = 1'b0; // slave waits for sync
	wire  [31:0] reg_rdata, rpdo_data, tpdo_data;
	wire         sync_tx, rpdo_valid, rpdo_ready, tpdo_valid, tpdo_update;
	int          failures = 0;
	int          n_checks = 0;
	int          i, n;
	logic [31:0] rd;  // last word read
	logic [31:0] n0;  // frame count before a step
	logic [7:0]  types [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
	logic [31:0] rst_val [10] = '{0, 32'h1F4, 32'hFF, 0, 32'hFF, 0, 0, 0, 0, 0};
	pds_sched #(.TICK_CYC(TICK)) dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sync_tx(sync_tx), .rpdo_valid(rpdo_valid), .rpdo_ready(rpdo_ready),
		.rpdo_data(rpdo_data), .tpdo_valid(tpdo_valid), .tpdo_data(tpdo_data),
		.tpdo_update(tpdo_update));
	pds_slave sl (.clk_sys(clk_sys), .srst(srst), .stall(stall), .sync_apply(sync_apply),
		.sync_tx(sync_tx), .rpdo_valid(rpdo_valid), .rpdo_ready(rpdo_ready),
		.rpdo_data(rpdo_data), .tpdo_valid(tpdo_valid), .tpdo_data(tpdo_data));
	// ==========================================================
	// helpers
	// ==========================================================
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict;
		if (failures == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one write cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask
	// one read cycle, data taken in the cycle after
	task automatic rdr(input logic [3:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	// bounded wait for the next sync, cycles counted in n
	task automatic wait_sync;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			#1 n++;
		end while (!sync_tx && n < 400);
		if (n >= 400)
		begin
			failures++;
			print_verdict();
		end
	endtask
	// bounded wait for one more frame at the slave
	task automatic wait_rx;
		for (n = 0; n < 40 && sl.n_rx == n0; n++)
			@(posedge clk_sys);
		chk("frame arrived", sl.n_rx, n0 + 1);
		if (sl.n_rx == n0)
			print_verdict();
	endtask
	initial
	begin
		forever #10 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// main sequence
	// ==========================================================
	initial
	begin
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		// reset values, unmapped index 9 last
		for (i = 0; i < 10; i++)
		begin
			rdr(i[3:0]);
			chk("reset value", rd, rst_val[i]);
		end
		// unmapped and read-only writes are ignored
		wr(4'h9, 32'h55);
		wr(`PDS_REG_TX_DATA, 32'h66);
		rdr(4'h9);
		chk("unmapped", rd, 32'h0);
		rdr(`PDS_REG_TX_DATA);
		chk("read-only", rd, 32'h0);
		// sync every 3 ticks
		wr(`PDS_REG_SYNC, 32'h3);
		wr(`PDS_REG_CTRL, 32'h1);
		wait_sync();
		wait_sync();
		chk("sync period", n, 3 * TICK);
		// change-driven types: one frame per change, none without
		for (i = 0; i < 4; i++)
		begin
			if (i == 1)
				continue;
			wr(`PDS_REG_RX_TYPE, {24'h0, types[i]});
			n0 = sl.n_rx;
			wr(`PDS_REG_RX_DATA, 32'hA0 + i);
			wait_rx();
			chk("sent word", sl.last_rx, 32'hA0 + i);
			wr(`PDS_REG_RX_DATA, 32'hA0 + i);
			repeat (20) @(posedge clk_sys);
			chk("no change no frame", sl.n_rx, n0 + 1);
		end
		// cyclic type 2: three frames in six syncs
		wr(`PDS_REG_RX_TYPE, 32'h2);
		n0 = sl.n_rx;
		sync_apply <= 1'b1;
		repeat (6) wait_sync();
		repeat (6) @(posedge clk_sys);
		chk("cyclic frames", sl.n_rx - n0, 32'h3);
		chk("cyclic word", sl.last_rx, 32'hA3);
		// stalled slave: buffer fills, newest word wins
		wr(`PDS_REG_RX_TYPE, 32'hFE);
		stall <= 1'b1;
		sync_apply <= 1'b0;
		n0 = sl.n_rx;
		// one word more than output stage, fifo and pending slot hold
		for (i = 1; i <= 11; i++)
			wr(`PDS_REG_RX_DATA, 32'h100 + i);
		rdr(`PDS_REG_STATUS);
		chk("full and pending", rd[4:3], 2'b11);
		stall <= 1'b0;
		repeat (60) @(posedge clk_sys);
		chk("newest word", sl.last_rx, 32'h10B);
		chk("frames after stall", sl.n_rx - n0, 32'hA);
		chk("applied at once", sl.applied, 32'h10B);
		rdr(`PDS_REG_STATUS);
		chk("drained", rd[4:3], 2'b00);
		// inbound frames valid at once for every type
		for (i = 0; i < 4; i++)
		begin
			wr(`PDS_REG_TX_TYPE, {24'h0, types[i]});
			sl.send(32'hC0 + i);
			rdr(`PDS_REG_TX_DATA);
			chk("inbound word", rd, 32'hC0 + i);
			rdr(`PDS_REG_STATUS);
			chk("fresh flag", rd[2:0], 3'h1);
			rdr(`PDS_REG_STATUS);
			chk("flag cleared", rd[2:0], 3'h0);
		end
		// slave breaks the inhibit gap on purpose
		wr(`PDS_REG_TX_INH, 32'h5);
		sl.send(32'hD1);
		sl.send(32'hD2);
		rdr(`PDS_REG_STATUS);
		chk("inhibit error", rd[1], 1'b1);
		// slave stays silent past one event period
		wr(`PDS_REG_TX_INH, 32'h0);
		wr(`PDS_REG_TX_EVENT, 32'h1);
		rdr(`PDS_REG_STATUS);
		repeat (250) @(posedge clk_sys);
		rdr(`PDS_REG_STATUS);
		chk("event error", rd[2], 1'b1);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
